// ===== pkg/clk_ctrl_pkg.sv
package clk_ctrl_pkg;

    // register map
    localparam logic [11:0] CLOCK_CONTROL_REG_ADDR = 12'h000;

    // clock_control_reg bit positions
    localparam int BIT_DIV_LO   = 0;
    localparam int BIT_DIV_HI   = 1;
    localparam int BIT_PM_EN    = 2;
    localparam int BIT_SWB_EN   = 3;
    localparam int BIT_STOP     = 4;
    localparam int BIT_RING_ACT = 5;
    localparam int BIT_RING_SEL = 6;
    localparam int BIT_CRYSTAL_OR_RC_SELECT    = 7;

    // values after reset
    localparam logic [1:0] DIV_SEL_RST  = 2'h0;
    localparam logic       CRYSTAL_OR_RC_SELECT_RST    = 1'h1;

    // oscillator cycles per system clock, minus one
    localparam logic [7:0] DIV_TC_1   = 8'h00;
    localparam logic [7:0] DIV_TC_2   = 8'h01;
    localparam logic [7:0] DIV_TC_4   = 8'h03;
    localparam logic [7:0] DIV_TC_8   = 8'h07;
    localparam logic [7:0] DIV_TC_256 = 8'hFF;

    // serial port modes
    localparam logic [1:0] SER_MODE_0 = 2'h0;

    // wake sources that can end power management mode
    typedef struct packed {
        logic       extIntEvent;    // external_interrupt_pin event
        logic       extIntEnable;
        logic       serialRxActive; // receive line active
        logic       serialRxEnable;
        logic [1:0] serialMode;
        logic       uartTxLoad;     // outgoing byte loaded
        logic       spiTransmitStandby;
        logic       spiSlaveSelect;
        logic       spiSlaveMode;
        logic       rtcTodAlarm;
        logic       rtcTodEnable;
        logic       rtcSubsecAlarm;
        logic       rtcSubsecEnable;
        logic       debugBreakMatch;
        logic       debugCommand;
    } wake_s;

endpackage

// ===== rtl/system_clock_divider_switchback.sv
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps

// Notes on behaviour
// RQ1: With power management off, the two divide select bits set the oscillator cycles per system clock.
// RQ2: With power management on, the divide select bits are ignored and the ratio is one in 256.
// RQ3: With switchback enabled and power management on, any active source clears the enable bit.
// RQ4: With switchback enabled, setting the power management bit only sticks when no source is active.
// RQ5: Serial receive activity in modes 1 to 3 with reception on, and enabled external interrupts, are sources.
// RQ6: Loading an outgoing UART byte while transmission is enabled is a source.
// RQ7: Assertion of SPI slave select in slave mode is a source.
// RQ8: Enabled RTC time-of-day and subsecond alarms are sources.
// RQ9: Entry into active debug mode by breakpoint or debug command is a source.
// RQ10: After switchback clears power management, the ratio follows the divide select bits.
// RQ11: Writing 1 to the stop bit enters stop mode and leaves divide bits and power management alone.
// RQ12: A read-only status bit reads 1 while the ring oscillator clocks the system, else 0.
// RQ13: Without a ring oscillator the status bit mirrors the ring select bit.
// RQ14: Setting ring select switches to the ring at once, keeps the ratio and may stop the crystal amplifier.
// RQ15: After ring select clears, the ring stays in use until the source warm-up completes.
// RQ16: The divider is a counter giving a one-cycle enable at terminal count and reloads on a ratio change.
module system_clock_divider_switchback #(
    parameter bit HAS_RING_OSC = 1'b1
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // wake sources and clock source status
    input  wire clk_ctrl_pkg::wake_s  wake,
    input  wire logic                 warmupDone,
    input  wire logic                 ampDisableAllowed,
    input  wire logic                 stopExit,
    // clock control outputs
    output logic                      sysClkEn,
    output logic                      stopMode,
    output logic                      ringOscActive,
    output logic                      crystalAmpEnable
);

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    // terminal count from the ratio controls
    function automatic logic [7:0] divTc(input logic pm, input logic [1:0] sel);
        logic [7:0] tc;
        tc = clk_ctrl_pkg::DIV_TC_1;
        if (pm) begin
            tc = clk_ctrl_pkg::DIV_TC_256;
        end else begin
            unique case (sel)
                2'h0: tc = clk_ctrl_pkg::DIV_TC_1;
                2'h1: tc = clk_ctrl_pkg::DIV_TC_2;
                2'h2: tc = clk_ctrl_pkg::DIV_TC_4;
                2'h3: tc = clk_ctrl_pkg::DIV_TC_8;
            endcase
        end
        return tc;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic [1:0] divSel_q;
    logic       pmEn_q;
    logic       swbEn_q;
    logic       stop_q;
    logic       ringSel_q;
    logic       ringAct_q;
    logic       xtRc_q;
    logic [7:0] divCnt_q;
    logic [7:0] divTc_q;
    logic       sysClkEn_q;
    logic       ampEn_q;
    logic       pready_q;
    logic       pslverr_q;
    logic [31:0] prdata_q;

    logic       wakeActive;
    logic       rxSrc;
    logic       intSrc;
    logic       txSrc;
    logic       spiSrc;
    logic       rtcSrc;
    logic       dbgSrc;
    logic       addrHit;
    logic       wrAccess;
    logic       wrLow;
    logic [7:0] regRead;
    logic [7:0] curTc;

    ////////////////////////////////////////////////////////////////////////////////
    // switchback sources

    // RQ5: receive and interrupt sources
    assign rxSrc  = wake.serialRxActive & wake.serialRxEnable &
                    (wake.serialMode != clk_ctrl_pkg::SER_MODE_0);
    assign intSrc = wake.extIntEvent & wake.extIntEnable;
    // RQ6: uart transmit load
    assign txSrc  = wake.uartTxLoad & wake.spiTransmitStandby;
    // RQ7: spi slave select
    assign spiSrc = wake.spiSlaveSelect & wake.spiSlaveMode;
    // RQ8: rtc alarm sources
    assign rtcSrc = (wake.rtcTodAlarm & wake.rtcTodEnable) |
                    (wake.rtcSubsecAlarm & wake.rtcSubsecEnable);
    // RQ9: debug mode entry
    assign dbgSrc = wake.debugBreakMatch | wake.debugCommand;

    assign wakeActive = rxSrc | intSrc | txSrc | spiSrc | rtcSrc | dbgSrc;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode

    // write lands at the completing access edge
    assign addrHit  = (paddr == clk_ctrl_pkg::CLOCK_CONTROL_REG_ADDR);
    assign wrAccess = psel & penable & pready_q & pwrite & addrHit;
    assign wrLow    = wrAccess & pstrb[0];

    // register image for reads
    always_comb begin
        regRead = 8'h00;
        regRead[clk_ctrl_pkg::BIT_DIV_HI:clk_ctrl_pkg::BIT_DIV_LO] = divSel_q;
        regRead[clk_ctrl_pkg::BIT_PM_EN]    = pmEn_q;
        regRead[clk_ctrl_pkg::BIT_SWB_EN]   = swbEn_q;
        regRead[clk_ctrl_pkg::BIT_STOP]     = stop_q;
        regRead[clk_ctrl_pkg::BIT_RING_ACT] = ringAct_q;
        regRead[clk_ctrl_pkg::BIT_RING_SEL] = ringSel_q;
        regRead[clk_ctrl_pkg::BIT_CRYSTAL_OR_RC_SELECT]    = xtRc_q;
    end

    // one wait-free access phase per transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'h0;
            pslverr_q <= 1'h0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~addrHit;
            if (psel & ~penable) begin
                prdata_q <= (addrHit & ~pwrite) ? {24'h00_0000, regRead} : 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control register

    // divide select, switchback enable, crystal or rc choice
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divSel_q <= clk_ctrl_pkg::DIV_SEL_RST;
            swbEn_q  <= 1'h0;
            xtRc_q   <= clk_ctrl_pkg::CRYSTAL_OR_RC_SELECT_RST;
        end else if (wrLow) begin
            divSel_q <= pwdata[clk_ctrl_pkg::BIT_DIV_HI:clk_ctrl_pkg::BIT_DIV_LO];
            swbEn_q  <= pwdata[clk_ctrl_pkg::BIT_SWB_EN];
            // source choice only changes while ring select is set
            if (ringSel_q) begin
                xtRc_q <= pwdata[clk_ctrl_pkg::BIT_CRYSTAL_OR_RC_SELECT];
            end
        end
    end

    // power management enable with switchback
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pmEn_q <= 1'h0;
        end else if (wrLow) begin
            // RQ4: set refused while a source is active
            if (pwdata[clk_ctrl_pkg::BIT_SWB_EN] & wakeActive) begin
                pmEn_q <= 1'h0;
            end else begin
                pmEn_q <= pwdata[clk_ctrl_pkg::BIT_PM_EN];
            end
        // RQ3: switchback clears power management
        end else if (swbEn_q & pmEn_q & wakeActive) begin
            pmEn_q <= 1'h0;
        end
    end

    // stop mode request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_q <= 1'h0;
        // RQ11: write of one enters stop
        end else if (wrLow & pwdata[clk_ctrl_pkg::BIT_STOP]) begin
            stop_q <= 1'h1;
        end else if (stopExit) begin
            stop_q <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ring oscillator selection

    // select bit and active status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ringSel_q <= 1'h0;
            ringAct_q <= 1'h0;
        end else begin
            if (wrLow) begin
                ringSel_q <= pwdata[clk_ctrl_pkg::BIT_RING_SEL];
            end
            if (!HAS_RING_OSC) begin
                // RQ13: status mirrors select
                ringAct_q <= wrLow ? pwdata[clk_ctrl_pkg::BIT_RING_SEL] : ringSel_q;
            // RQ14: ring taken at once
            end else if (wrLow & pwdata[clk_ctrl_pkg::BIT_RING_SEL]) begin
                ringAct_q <= 1'h1;
            // RQ15: hold ring until warm-up done
            end else if (!ringSel_q & warmupDone) begin
                ringAct_q <= 1'h0;
            end
        end
    end

    // RQ14: crystal amplifier off on ring select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ampEn_q <= 1'h1;
        end else begin
            ampEn_q <= ~(ringSel_q & ampDisableAllowed);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // divider

    // RQ1: ratio from select bits, RQ2: fixed 256, RQ10: follows select after switchback
    assign curTc = divTc(pmEn_q, divSel_q);

    // RQ16: counter with reload on ratio change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divTc_q    <= clk_ctrl_pkg::DIV_TC_1;
            divCnt_q   <= 8'h00;
            sysClkEn_q <= 1'h0;
        end else begin
            divTc_q <= curTc;
            if (stop_q) begin
                divCnt_q   <= 8'h00; // no system clock in stop
                sysClkEn_q <= 1'h0;
            end else if (curTc != divTc_q) begin
                divCnt_q   <= 8'h00;
                sysClkEn_q <= 1'h0;
            end else if (divCnt_q >= divTc_q) begin
                divCnt_q   <= 8'h00;
                sysClkEn_q <= 1'h1;
            end else begin
                divCnt_q   <= divCnt_q + 8'h01;
                sysClkEn_q <= 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign prdata           = prdata_q;
    assign sysClkEn         = sysClkEn_q;
    assign stopMode         = stop_q;
    // RQ12: ring status output
    assign ringOscActive    = ringAct_q;
    assign crystalAmpEnable = ampEn_q;

endmodule

// ===== sim/clk_ctrl_props.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// port-level checks of the clock control block
module clk_ctrl_props #(
    parameter bit HAS_RING_OSC = 1'b1
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // clock control
    input wire logic        warmupDone,
    input wire logic        ampDisableAllowed,
    input wire logic        stopExit,
    input wire logic        sysClkEn,
    input wire logic        stopMode,
    input wire logic        ringOscActive,
    input wire logic        crystalAmpEnable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic wrOk;

    // accepted write to the control register
    assign wrOk = psel && penable && pwrite && pready && paddr == 12'h000 && pstrb[0];

    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence

    a_ready_setup: assert property (s_setup |-> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_idle: assert property (!psel |=> !pready)
        else $error("ready without setup");
    a_err_addr: assert property (pready |-> pslverr == (paddr != 12'h000))
        else $error("error flag wrong for address");
    a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("read data on error not zero");
    a_stop_set: assert property (
        wrOk && pwdata[4] && !stopExit |=> stopMode) else $error("stop not entered");
    a_stop_quiet: assert property (
        stopMode && $past(stopMode) |-> !sysClkEn) else $error("clock enable in stop");
    a_ring_now: assert property (
        wrOk && pwdata[6] |=> ringOscActive) else $error("ring not selected at once");
    a_amp_off: assert property (
        wrOk && pwdata[6] && ampDisableAllowed |-> ##[1:2] !crystalAmpEnable)
        else $error("amplifier left on");
    a_ring_held: assert property (
        HAS_RING_OSC && ringOscActive && !warmupDone |=> ringOscActive)
        else $error("ring left before warm-up");
endmodule

bind system_clock_divider_switchback clk_ctrl_props #(.HAS_RING_OSC(HAS_RING_OSC)) u_props (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .warmupDone(warmupDone), .ampDisableAllowed(ampDisableAllowed),
    .stopExit(stopExit), .sysClkEn(sysClkEn), .stopMode(stopMode),
    .ringOscActive(ringOscActive), .crystalAmpEnable(crystalAmpEnable));

// ===== sim/system_clock_divider_switchback_tb_top.sv
`timescale 1ns/10ps

module system_clock_divider_switchback_tb_top;
    logic                clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic                warmupDone, ampDisableAllowed, stopExit;
    logic                sysClkEn, stopMode, ringOscActive, crystalAmpEnable;
    logic [11:0]         paddr;
    logic [3:0]          pstrb;
    logic [31:0]         pwdata, prdata, rd;
    clk_ctrl_pkg::wake_s wake;
    int                  n_errors, num_checks, cyc;
    // one wake source each; last two must not wake
    logic [15:0]         srcTbl [10] = '{16'hC000, 16'h3400, 16'h0300, 16'h00C0, 16'h0030,
                                         16'h000C, 16'h0002, 16'h0001, 16'h8000, 16'h3000};

    system_clock_divider_switchback dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .wake(wake), .warmupDone(warmupDone),
        .ampDisableAllowed(ampDisableAllowed), .stopExit(stopExit), .sysClkEn(sysClkEn),
        .stopMode(stopMode), .ringOscActive(ringOscActive),
        .crystalAmpEnable(crystalAmpEnable));

    ////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            conclude();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [7:0] e);
        apb(1'b0, 12'h000, 8'h00);
        chk(rd, {24'h0, e});
    endtask

    // skip two pulses after a change, then time one period
    task gap(input int e);
        int n;
        repeat (2) do @(posedge clk); while (sysClkEn !== 1'b1);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sysClkEn !== 1'b1 && n < 600);
        chk(32'(n), 32'(e));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_ratio;
        rdchk(8'h80);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, 8'h80 | 8'(i));
            gap(1 << i);
        end
        apb(1'b1, 12'h000, 8'h86);
        gap(256);
    endtask

    task t_wake;
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, 12'h000, 8'h8E);
            rdchk(8'h8E);
            @(posedge clk);
            wake <= clk_ctrl_pkg::wake_s'(srcTbl[i]);
            @(posedge clk);
            wake <= '0;
            rdchk(i < 8 ? 8'h8A : 8'h8E);
        end
        @(posedge clk);
        wake <= clk_ctrl_pkg::wake_s'(16'h0030);
        apb(1'b1, 12'h000, 8'h8E);
        rdchk(8'h8A);
        gap(4);
        wake <= '0;
    endtask

    task t_stop;
        apb(1'b1, 12'h000, 8'h81);
        apb(1'b1, 12'h000, 8'h91);
        rdchk(8'h91);
        @(posedge clk);
        stopExit <= 1'b1;
        @(posedge clk);
        stopExit <= 1'b0;
        @(negedge clk);
        chk({31'h0, stopMode}, 32'h0);
        gap(2);
    endtask

    task t_ring;
        @(posedge clk);
        warmupDone <= 1'b0;
        apb(1'b1, 12'h000, 8'hC1);
        rdchk(8'hE1);
        gap(2);
        // source choice writable while ring select is set
        apb(1'b1, 12'h000, 8'h41);
        rdchk(8'h61);
        // drop ring select, ring held until warm-up
        apb(1'b1, 12'h000, 8'h01);
        repeat (20) @(posedge clk);
        rdchk(8'h21);
        warmupDone <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(8'h01);
        apb(1'b1, 12'h004, 8'h00);
        chk({31'h0, err}, 32'h1);
        rdchk(8'h01);
        // write with low byte lane off is ignored
        pstrb <= 4'h0;
        apb(1'b1, 12'h000, 8'h03);
        pstrb <= 4'hF;
        rdchk(8'h01);
        apb(1'b0, 12'h004, 8'h00);
        chk(rd, 32'h0);
    endtask

    task conclude;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, stopExit} = 5'h00;
        {warmupDone, ampDisableAllowed} = 2'h3;
        paddr = 12'h000;
        pstrb = 4'hF;
        pwdata = 32'h0;
        wake = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_ratio();
        t_wake();
        t_stop();
        t_ring();
        conclude();
    end
endmodule
